// ### src/ccr_storage_ctrl.sv
`timescale 1ns/1ps
// How it works
// - pager hit joins page with nine offset bits
// - pager miss asks execution unit for refill
// - execution unit moves exactly one word
// - channel end multiplexes eight transfer slots
// - blocks of four words via four buffers
// - channel raises request when it needs service
// - reserve line blocks execution-unit core cycles
// - grant raised when channel request processing starts
// - write waits begin_core; read starts itself
// - channel selects buffer with two-bit code
// - channel strobes load into selected buffer
// - word-ready marks each loaded buffer on reads
// - channel checks parity before taking word; the device evaluates the check line on writes only, so read words go unchecked
// - direction qualifier picks write or read
// - four mask bits mark requested words
// - exec-table qualifier substitutes table address
// - parity error pulses one clock
// - parity checked on write check line only; read load clears it
// - channel holds address and qualifiers stable
// - word-ready low one tick means loaded
// - channel takes words ascending modulo four
// - exec base replaces address bits 9..21
module ccr_storage_ctrl #(
  parameter int MEM_DEPTH = ccr_pkg::MEM_DEPTH
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  ccr_link_if.device link,
  input wire logic exec_req_in,
  input wire logic exec_write_in,
  input wire logic exec_paged_in,
  input wire logic [ccr_pkg::ADDR_W-1:0] exec_addr_in,
  input wire logic [ccr_pkg::WORD_W-1:0] exec_wdata_in,
  input wire logic [ccr_pkg::EXEC_BASE_W-1:0] exec_base_in,
  input wire logic pager_fill_in,
  input wire logic [ccr_pkg::VPAGE_W-1:0] pager_fill_vpage_in,
  input wire logic [ccr_pkg::PPAGE_W-1:0] pager_fill_ppage_in,
  output logic exec_done_out,
  output logic exec_refill_out,
  output logic [ccr_pkg::WORD_W-1:0] exec_rdata_out
);
  localparam int IDX_W = $clog2(ccr_pkg::PAGER_DEPTH / ccr_pkg::PAGER_WAYS);
  localparam int TAG_W = ccr_pkg::VPAGE_W - IDX_W;
  localparam int MA_W = $clog2(MEM_DEPTH);
  localparam int SETS = ccr_pkg::PAGER_DEPTH / ccr_pkg::PAGER_WAYS;

  typedef enum logic [2:0] {
    CCR_IDLE, CCR_CH_WAIT, CCR_CH_CORE, CCR_CH_DONE, CCR_EX_CORE
  } ccr_state_t;

  function automatic logic par_of(input logic [ccr_pkg::WORD_W-1:0] w);
    par_of = ^w;
  endfunction

  // =========================================
  // storage
  // =========================================
  logic [ccr_pkg::WORD_W-1:0] core_mem [MEM_DEPTH];
  logic [ccr_pkg::WORD_W:0] xfer_buf [ccr_pkg::NUM_BUF];
  logic pg_valid [ccr_pkg::PAGER_WAYS][SETS];
  logic [TAG_W-1:0] pg_tag [ccr_pkg::PAGER_WAYS][SETS];
  logic [ccr_pkg::PPAGE_W-1:0] pg_page [ccr_pkg::PAGER_WAYS][SETS];
  logic pg_victim;

  ccr_state_t state;
  logic [2:0] core_cnt;
  logic [1:0] word_idx;
  logic [ccr_pkg::ADDR_W-1:0] eff_addr;
  logic [ccr_pkg::NUM_BUF-1:0] ready_pulse;
  logic exec_wr_q;
  logic [ccr_pkg::ADDR_W-1:0] exec_pa;

  // =========================================
  // pager lookup
  // =========================================
  logic [IDX_W-1:0] lk_idx;
  logic [TAG_W-1:0] lk_tag;
  logic hit0;
  logic hit1;
  logic pg_hit;
  logic [ccr_pkg::PPAGE_W-1:0] hit_page;
  logic [ccr_pkg::VPAGE_W-1:0] ex_vpage;
  logic [ccr_pkg::ADDR_W-1:0] ex_addr;
  assign ex_vpage = exec_addr_in[ccr_pkg::ADDR_W-1 -: ccr_pkg::VPAGE_W];
  assign lk_idx = ex_vpage[IDX_W-1:0];
  assign lk_tag = ex_vpage[ccr_pkg::VPAGE_W-1:IDX_W];
  assign hit0 = pg_valid[0][lk_idx] && pg_tag[0][lk_idx] == lk_tag;
  assign hit1 = pg_valid[1][lk_idx] && pg_tag[1][lk_idx] == lk_tag;
  assign pg_hit = hit0 || hit1;
  assign hit_page = hit0 ? pg_page[0][lk_idx] : pg_page[1][lk_idx];
  assign ex_addr = exec_paged_in ?
    {hit_page, exec_addr_in[ccr_pkg::PAGE_OFS_W-1:0]} : exec_addr_in;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pg_valid <= '{default: '0};
      pg_victim <= 1'b0;
    end else if (pager_fill_in) begin
      pg_valid[pg_victim][pager_fill_vpage_in[IDX_W-1:0]] <= 1'b1;
      pg_victim <= ~pg_victim;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (pager_fill_in) begin
      pg_tag[pg_victim][pager_fill_vpage_in[IDX_W-1:0]] <=
        pager_fill_vpage_in[ccr_pkg::VPAGE_W-1:IDX_W];
      pg_page[pg_victim][pager_fill_vpage_in[IDX_W-1:0]] <= pager_fill_ppage_in;
    end
  end

  // =========================================
  // channel address forming
  // =========================================
  logic [ccr_pkg::ADDR_W-1:0] ch_addr;
  always_comb begin
    ch_addr = link.channel_address;
    if (link.exec_table_access) begin
      ch_addr[ccr_pkg::EXEC_BASE_LSB +: ccr_pkg::EXEC_BASE_W] = exec_base_in;
    end
  end

  logic word_wanted;
  assign word_wanted = link.word_request_mask[word_idx];
  logic [MA_W-1:0] word_ma;
  assign word_ma = MA_W'({eff_addr[ccr_pkg::ADDR_W-1:2], word_idx});

  // =========================================
  // cycle control
  // =========================================
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= CCR_IDLE;
      core_cnt <= 3'h0;
      word_idx <= 2'h0;
      eff_addr <= '0;
      exec_wr_q <= 1'b0;
      exec_pa <= '0;
    end else begin
      case (state)
        CCR_IDLE: begin
          core_cnt <= 3'h0;
          word_idx <= 2'h0;
          if (link.io_channel_request) begin
            eff_addr <= ch_addr;
            state <= CCR_CH_WAIT;
          end else if (exec_req_in && !link.reserve_next_core_cycle) begin
            if (!exec_paged_in || pg_hit) begin
              exec_pa <= ex_addr;
              exec_wr_q <= exec_write_in;
              state <= CCR_EX_CORE;
            end
          end
        end
        CCR_CH_WAIT: begin
          if (!link.write_direction_qualifier || link.begin_core_cycle) begin
            state <= CCR_CH_CORE;
          end
        end
        CCR_CH_CORE: begin
          if (core_cnt == 3'(ccr_pkg::CORE_CYCLES - 1)) begin
            core_cnt <= 3'h0;
            word_idx <= word_idx + 2'h1;
            if (word_idx == 2'(ccr_pkg::NUM_BUF - 1)) begin
              state <= CCR_CH_DONE;
            end
          end else begin
            core_cnt <= core_cnt + 3'h1;
          end
        end
        CCR_CH_DONE: begin
          state <= CCR_IDLE;
        end
        CCR_EX_CORE: begin
          if (core_cnt == 3'(ccr_pkg::CORE_CYCLES - 1)) begin
            state <= CCR_IDLE;
          end else begin
            core_cnt <= core_cnt + 3'h1;
          end
        end
        default: state <= CCR_IDLE;
      endcase
    end
  end

  logic ch_word_step;
  assign ch_word_step = state == CCR_CH_CORE &&
    core_cnt == 3'(ccr_pkg::CORE_CYCLES - 1) && word_wanted;

  // the word being strobed in is checked, not the stale buffer content
  logic [ccr_pkg::WORD_W:0] chk_word;
  assign chk_word = link.buffer_load_strobe ? link.chan_to_buffer :
    xfer_buf[link.buffer_select_code];

  // =========================================
  // buffers and memory
  // =========================================
  always_ff @(posedge sys_clk_in) begin
    if (state == CCR_CH_WAIT || state == CCR_CH_CORE) begin
      if (link.write_direction_qualifier && link.buffer_load_strobe) begin
        xfer_buf[link.buffer_select_code] <= link.chan_to_buffer;
      end
    end
    if (ch_word_step) begin
      if (link.write_direction_qualifier) begin
        core_mem[word_ma] <= xfer_buf[word_idx][ccr_pkg::WORD_W-1:0];
      end else begin
        xfer_buf[word_idx] <= {par_of(core_mem[word_ma]), core_mem[word_ma]};
      end
    end
    if (state == CCR_EX_CORE && core_cnt == 3'(ccr_pkg::CORE_CYCLES - 1) && exec_wr_q) begin
      core_mem[MA_W'(exec_pa)] <= exec_wdata_in;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ready_pulse <= '0;
      link.buffer_parity_error <= 1'b0;
      exec_rdata_out <= '0;
      link.buffer_to_chan <= '0;
    end else begin
      ready_pulse <= '0;
      if (ch_word_step && !link.write_direction_qualifier) begin
        ready_pulse[word_idx] <= 1'b1;
      end
      // one-cycle parity error: write on check line; a read load clears it
      link.buffer_parity_error <= 1'b0;
      if (link.write_direction_qualifier && link.buffer_parity_check &&
          link.channel_cycle_grant) begin
        link.buffer_parity_error <= par_of(chk_word[ccr_pkg::WORD_W-1:0])
          != chk_word[ccr_pkg::WORD_W];
      end else if (ch_word_step && !link.write_direction_qualifier) begin
        link.buffer_parity_error <= 1'b0;
      end
      link.buffer_to_chan <= xfer_buf[link.buffer_select_code];
      if (state == CCR_EX_CORE && core_cnt == 3'(ccr_pkg::CORE_CYCLES - 1) && !exec_wr_q) begin
        exec_rdata_out <= core_mem[MA_W'(exec_pa)];
      end
    end
  end

  assign link.buffer_word_ready = ~ready_pulse;
  assign link.channel_cycle_grant = state == CCR_CH_WAIT || state == CCR_CH_CORE ||
    state == CCR_CH_DONE;
  assign link.request_done = state == CCR_CH_DONE;
  assign exec_done_out = state == CCR_EX_CORE && core_cnt == 3'(ccr_pkg::CORE_CYCLES - 1);
  assign exec_refill_out = state == CCR_IDLE && !link.io_channel_request && exec_req_in &&
    !link.reserve_next_core_cycle && exec_paged_in && !pg_hit;
endmodule

// ### src/ccr_pkg.sv
package ccr_pkg;
  // word and address geometry
  localparam int WORD_W = 36;
  localparam int ADDR_W = 22;
  localparam int PAGE_OFS_W = 9;
  localparam int VPAGE_W = 13;
  localparam int PPAGE_W = 13;
  localparam int PAGER_DEPTH = 512;
  localparam int PAGER_WAYS = 2;
  localparam int NUM_BUF = 4;
  localparam int SEL_W = 2;
  localparam int NUM_CHAN = 8;
  // exec-table base replaces the upper address field
  localparam int EXEC_BASE_W = 13;
  localparam int EXEC_BASE_LSB = 9;
  // cycles of simulated core access
  localparam int CORE_CYCLES = 4;
  localparam int MEM_DEPTH = 64;
  localparam logic [3:0] WORD_REQ_RESET = 4'h0;
  typedef enum logic [1:0] {CCR_SRC_NONE, CCR_SRC_EXEC, CCR_SRC_CHAN} ccr_src_t;
endpackage

// ### src/ccr_link_if.sv
`timescale 1ns/1ps
interface ccr_link_if;
  logic io_channel_request;
  logic reserve_next_core_cycle;
  logic channel_cycle_grant;
  logic begin_core_cycle;
  logic [ccr_pkg::SEL_W-1:0] buffer_select_code;
  logic buffer_load_strobe;
  logic [ccr_pkg::NUM_BUF-1:0] buffer_word_ready;
  logic buffer_parity_check;
  logic write_direction_qualifier;
  logic [ccr_pkg::NUM_BUF-1:0] word_request_mask;
  logic exec_table_access;
  logic buffer_parity_error;
  logic request_done;
  logic [ccr_pkg::ADDR_W-1:0] channel_address;
  logic [ccr_pkg::WORD_W:0] chan_to_buffer;
  logic [ccr_pkg::WORD_W:0] buffer_to_chan;
  modport device (
    input io_channel_request, reserve_next_core_cycle, begin_core_cycle,
    input buffer_select_code, buffer_load_strobe, buffer_parity_check,
    input write_direction_qualifier, word_request_mask, exec_table_access,
    input channel_address, chan_to_buffer,
    output channel_cycle_grant, buffer_word_ready, buffer_parity_error,
    output request_done, buffer_to_chan
  );
  modport channel (
    output io_channel_request, reserve_next_core_cycle, begin_core_cycle,
    output buffer_select_code, buffer_load_strobe, buffer_parity_check,
    output write_direction_qualifier, word_request_mask, exec_table_access,
    output channel_address, chan_to_buffer,
    input channel_cycle_grant, buffer_word_ready, buffer_parity_error,
    input request_done, buffer_to_chan
  );
endinterface

// ### src/ccr_channel_end.sv
`timescale 1ns/1ps
// channel side: eight slots share the link, read words pass a two-entry buffer
module ccr_channel_end #(
  parameter int NUM_CHAN = ccr_pkg::NUM_CHAN
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  ccr_link_if.channel link,
  input wire logic [NUM_CHAN-1:0] slot_req_in,
  input wire logic slot_write_in,
  input wire logic slot_exec_table_in,
  input wire logic [3:0] slot_mask_in,
  input wire logic [ccr_pkg::ADDR_W-1:0] slot_addr_in,
  input wire logic [ccr_pkg::WORD_W-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [ccr_pkg::WORD_W-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [NUM_CHAN-1:0] slot_ack_out,
  output logic parity_fault_out
);
  localparam int SLOT_W = $clog2(NUM_CHAN);
  typedef enum logic [1:0] {CCR_C_IDLE, CCR_C_REQ, CCR_C_MOVE} ccr_chan_state_t;

  ccr_chan_state_t state;
  logic [SLOT_W-1:0] slot;
  logic [SLOT_W-1:0] rr_ptr;
  logic [1:0] sel;
  logic [3:0] pending;
  logic wr;
  logic exec_process_table;
  logic [ccr_pkg::ADDR_W-1:0] addr;
  logic [3:0] mask;
  logic chk_wait;
  logic [3:0] loaded;
  logic got_done;
  // two-entry read buffer
  logic [ccr_pkg::WORD_W-1:0] fb [2];
  logic [1:0] fb_cnt;
  logic fb_wp;
  logic fb_rp;

  function automatic logic [1:0] low_bit(input logic [3:0] m);
    low_bit = m[0] ? 2'h0 : m[1] ? 2'h1 : m[2] ? 2'h2 : 2'h3;
  endfunction

  // =========================================
  // slot pick and request
  // =========================================
  logic any_slot;
  logic [SLOT_W-1:0] pick;
  // a slot being acknowledged is not picked again
  logic [NUM_CHAN-1:0] elig;
  assign elig = slot_req_in & ~slot_ack_out;
  always_comb begin
    pick = rr_ptr;
    any_slot = 1'b0;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (elig[SLOT_W'(rr_ptr + SLOT_W'(i))]) begin
        pick = SLOT_W'(rr_ptr + SLOT_W'(i));
        any_slot = 1'b1;
      end
    end
  end

  logic take_word;
  logic want_rd;
  // a ready low is latched so that a full buffer loses no word
  assign want_rd = state == CCR_C_MOVE && !wr && pending[sel] && !chk_wait &&
    (loaded[sel] || !link.buffer_word_ready[sel]);
  assign take_word = chk_wait;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= CCR_C_IDLE;
      slot <= '0;
      rr_ptr <= '0;
      sel <= 2'h0;
      pending <= ccr_pkg::WORD_REQ_RESET;
      wr <= 1'b0;
      exec_process_table <= 1'b0;
      addr <= '0;
      mask <= ccr_pkg::WORD_REQ_RESET;
      chk_wait <= 1'b0;
      loaded <= 4'h0;
      got_done <= 1'b0;
      slot_ack_out <= '0;
      parity_fault_out <= 1'b0;
    end else begin
      slot_ack_out <= '0;
      parity_fault_out <= link.buffer_parity_error;
      chk_wait <= 1'b0;
      case (state)
        CCR_C_IDLE: begin
          if (any_slot && slot_mask_in != 4'h0) begin
            slot <= pick;
            rr_ptr <= SLOT_W'(pick + SLOT_W'(1));
            wr <= slot_write_in;
            exec_process_table <= slot_exec_table_in;
            addr <= slot_addr_in;
            mask <= slot_mask_in;
            pending <= slot_mask_in;
            loaded <= 4'h0;
            got_done <= 1'b0;
            sel <= low_bit(slot_mask_in);
            state <= CCR_C_REQ;
          end
        end
        CCR_C_REQ: begin
          if (link.channel_cycle_grant) begin
            state <= CCR_C_MOVE;
          end
        end
        CCR_C_MOVE: begin
          if (wr && pending[sel] && wr_valid_in) begin
            pending[sel] <= 1'b0;
            sel <= sel + 2'h1;
          end else if (wr && !pending[sel] && pending != 4'h0) begin
            sel <= sel + 2'h1;
          end
          if (want_rd && fb_cnt != 2'h2) begin
            chk_wait <= 1'b1;
          end
          if (take_word) begin
            pending[sel] <= 1'b0;
            sel <= sel + 2'h1;
          end else if (!wr && !pending[sel] && pending != 4'h0) begin
            sel <= sel + 2'h1;
          end
          loaded <= loaded | ~link.buffer_word_ready;
          if (link.request_done) begin
            got_done <= 1'b1;
          end
          // a stalled reader may still owe words after the device is done
          if ((link.request_done || got_done) && (wr || pending == 4'h0)) begin
            slot_ack_out[slot] <= 1'b1;
            state <= CCR_C_IDLE;
          end
        end
        default: state <= CCR_C_IDLE;
      endcase
    end
  end

  // =========================================
  // two-entry buffer toward the user
  // =========================================
  logic fb_push;
  logic fb_pop;
  assign fb_push = take_word;
  assign fb_pop = rd_valid_out && rd_ready_in;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fb_cnt <= 2'h0;
      fb_wp <= 1'b0;
      fb_rp <= 1'b0;
    end else begin
      if (fb_push) begin
        fb_wp <= ~fb_wp;
      end
      if (fb_pop) begin
        fb_rp <= ~fb_rp;
      end
      fb_cnt <= fb_cnt + {1'b0, fb_push} - {1'b0, fb_pop};
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (fb_push) begin
      fb[fb_wp] <= link.buffer_to_chan[ccr_pkg::WORD_W-1:0];
    end
  end
  assign rd_valid_out = fb_cnt != 2'h0;
  assign rd_data_out = fb[fb_rp];

  // =========================================
  // link drive
  // =========================================
  logic moving;
  assign moving = state == CCR_C_MOVE;
  assign link.io_channel_request = state == CCR_C_REQ;
  assign link.reserve_next_core_cycle = state != CCR_C_IDLE || any_slot;
  assign link.write_direction_qualifier = wr;
  assign link.exec_table_access = exec_process_table;
  assign link.word_request_mask = mask;
  assign link.channel_address = addr;
  assign link.buffer_select_code = sel;
  assign link.buffer_load_strobe = moving && wr && pending[sel] && wr_valid_in;
  assign link.chan_to_buffer = {^wr_data_in, wr_data_in};
  assign link.begin_core_cycle = moving && wr && pending == 4'h0;
  assign link.buffer_parity_check = (moving && wr && pending[sel] && wr_valid_in) || want_rd;
  assign wr_ready_out = moving && wr && pending[sel];
endmodule

// ### test/ccr_link_props.sv
`timescale 1ns/1ps
module ccr_link_props (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic io_channel_request,
  input wire logic channel_cycle_grant,
  input wire logic begin_core_cycle,
  input wire logic buffer_load_strobe,
  input wire logic [ccr_pkg::NUM_BUF-1:0] buffer_word_ready,
  input wire logic write_direction_qualifier,
  input wire logic [ccr_pkg::NUM_BUF-1:0] word_request_mask,
  input wire logic exec_table_access,
  input wire logic buffer_parity_error,
  input wire logic request_done,
  input wire logic [ccr_pkg::ADDR_W-1:0] channel_address
);
  // ==========================================
  // link properties
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  property p_grant_cause;
    $rose(channel_cycle_grant) |-> $past(io_channel_request);
  endproperty
  a_grant_cause: assert property (p_grant_cause) else $error("grant without request");
  property p_grant_ends;
    $rose(channel_cycle_grant) |-> ##[1:400] request_done;
  endproperty
  a_grant_ends: assert property (p_grant_ends) else $error("request never done");
  property p_done_in_grant;
    request_done |-> channel_cycle_grant;
  endproperty
  a_done_in_grant: assert property (p_done_in_grant) else $error("done outside grant");
  property p_ready_pulse;
    (~buffer_word_ready & ~$past(buffer_word_ready)) == 4'h0;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("word ready low too long");
  property p_ready_read;
    buffer_word_ready != 4'hF |-> channel_cycle_grant && !write_direction_qualifier;
  endproperty
  a_ready_read: assert property (p_ready_read) else $error("word ready outside read");
  property p_ready_mask;
    (~buffer_word_ready & ~word_request_mask) == 4'h0;
  endproperty
  a_ready_mask: assert property (p_ready_mask) else $error("unrequested word ready");
  property p_strobe_write;
    buffer_load_strobe |-> channel_cycle_grant && write_direction_qualifier;
  endproperty
  a_strobe_write: assert property (p_strobe_write) else $error("load strobe misplaced");
  property p_begin_write;
    begin_core_cycle |-> channel_cycle_grant && write_direction_qualifier;
  endproperty
  a_begin_write: assert property (p_begin_write) else $error("begin core misplaced");
  property p_err_pulse;
    buffer_parity_error |=> !buffer_parity_error;
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("parity error too long");
  property p_qual_stable;
    channel_cycle_grant && !request_done |=> $stable(channel_address)
      && $stable(word_request_mask) && $stable(write_direction_qualifier)
      && $stable(exec_table_access);
  endproperty
  a_qual_stable: assert property (p_qual_stable) else $error("qualifier moved");
  c_write: cover property (channel_cycle_grant && buffer_load_strobe);
  c_read: cover property (buffer_word_ready != 4'hF);
  c_table: cover property ($rose(channel_cycle_grant) && exec_table_access);
endmodule

// ### test/channel_cache_request_interface_test.sv
`timescale 1ns/1ps
module channel_cache_request_interface_test;
  logic sys_clk_in, rst_in, exec_req_in, exec_write_in, exec_paged_in, pager_fill_in;
  logic exec_done_out, exec_refill_out, slot_write_in, slot_exec_table_in;
  logic wr_valid_in, wr_ready_out, rd_valid_out, rd_ready_in, parity_fault_out;
  logic [ccr_pkg::ADDR_W-1:0] exec_addr_in, slot_addr_in;
  logic [ccr_pkg::WORD_W-1:0] exec_wdata_in, exec_rdata_out, wr_data_in, rd_data_out;
  logic [ccr_pkg::EXEC_BASE_W-1:0] exec_base_in;
  logic [ccr_pkg::VPAGE_W-1:0] pager_fill_vpage_in;
  logic [ccr_pkg::PPAGE_W-1:0] pager_fill_ppage_in;
  logic [7:0] slot_req_in, slot_ack_out, ackd;
  logic [3:0] slot_mask_in;
  logic [ccr_pkg::WORD_W-1:0] wdat [4];
  logic [ccr_pkg::WORD_W-1:0] edat [4];
  logic saw_res;
  int errors, comparisons, k, got, done_at, first_ack;
  ccr_link_if link();
  ccr_storage_ctrl u_ccr_storage_ctrl (.sys_clk_in, .rst_in, .link(link), .exec_req_in,
    .exec_write_in, .exec_paged_in, .exec_addr_in, .exec_wdata_in, .exec_base_in,
    .pager_fill_in, .pager_fill_vpage_in, .pager_fill_ppage_in, .exec_done_out,
    .exec_refill_out, .exec_rdata_out);
  ccr_channel_end u_ccr_channel_end (.sys_clk_in, .rst_in, .link(link), .slot_req_in,
    .slot_write_in, .slot_exec_table_in, .slot_mask_in, .slot_addr_in, .wr_data_in,
    .wr_valid_in, .wr_ready_out, .rd_data_out, .rd_valid_out, .rd_ready_in, .slot_ack_out,
    .parity_fault_out);
  ccr_link_props u_ccr_link_props (.sys_clk_in, .rst_in,
    .io_channel_request(link.io_channel_request),
    .channel_cycle_grant(link.channel_cycle_grant), .begin_core_cycle(link.begin_core_cycle),
    .buffer_load_strobe(link.buffer_load_strobe), .buffer_word_ready(link.buffer_word_ready),
    .write_direction_qualifier(link.write_direction_qualifier),
    .word_request_mask(link.word_request_mask), .exec_table_access(link.exec_table_access),
    .buffer_parity_error(link.buffer_parity_error), .request_done(link.request_done),
    .channel_address(link.channel_address));
  // ==========================================
  // tasks
  task automatic close_out;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [35:0] g, input logic [35:0] e, input string what);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask
  task automatic step;
    @(posedge sys_clk_in);
    #1;
  endtask
  function automatic int nth(input logic [3:0] m, input int n);
    int c;
    c = 0;
    for (int i = 0; i < 4; i++) begin
      if (m[i] && c == n) return i;
      if (m[i]) c++;
    end
    return 0;
  endfunction
  // one channel request from slot 0; words move through the valid-ready sides
  task automatic xfer(input logic wr, input logic tbl, input logic [3:0] m,
      input logic [21:0] a, input int stall);
    int n, put, cyc;
    logic acked;
    n = $countones(m);
    put = 0;
    got = 0;
    cyc = 0;
    acked = 0;
    {slot_write_in, slot_exec_table_in, slot_mask_in, slot_addr_in} = {wr, tbl, m, a};
    slot_req_in = 8'h01;
    while (cyc < 600 && (!acked || (wr ? put : got) < n)) begin
      wr_valid_in = wr && put < n;
      wr_data_in = wdat[nth(m, put)];
      rd_ready_in = cyc >= stall;
      #18;
      if (slot_ack_out[0] === 1'b1) acked = 1;
      chk(36'(parity_fault_out), 36'h0, "parity fault");
      if (wr_valid_in && wr_ready_out === 1'b1) put++;
      if (rd_ready_in && rd_valid_out === 1'b1) begin
        chk(rd_data_out, edat[nth(m, got)], "channel read word");
        got++;
      end
      step();
      if (acked) slot_req_in = 8'h00;
      cyc++;
    end
    wr_valid_in = 0;
    rd_ready_in = 0;
    chk(36'(cyc < 600), 36'h1, "transfer finished");
    cyc = 0;
    while (cyc < 400 && (link.io_channel_request | link.channel_cycle_grant) !== 1'b0) begin
      step();
      cyc++;
    end
  endtask
  task automatic exec_op(input logic wr, input logic pg, input logic [21:0] a,
      input logic [35:0] wd, input logic e_ref, input logic [35:0] e);
    logic dn, rf;
    {exec_write_in, exec_paged_in, exec_addr_in, exec_wdata_in} = {wr, pg, a, wd};
    exec_req_in = 1;
    k = 0;
    {dn, rf} = 2'b00;
    while (k < 600 && !dn && !rf) begin
      #18;
      {dn, rf} = {exec_done_out === 1'b1, exec_refill_out === 1'b1};
      step();
      k++;
    end
    exec_req_in = 0;
    chk(36'({dn, rf}), 36'({!e_ref, e_ref}), "exec outcome");
    if (!wr && !e_ref) chk(exec_rdata_out, e, "exec read");
  endtask
  // ==========================================
  // clock, watchdog, tests
  initial begin
    sys_clk_in = 0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    #600000;
    errors++;
    $display("BAD %0t watchdog expired", $time);
    close_out();
  end
  initial begin
    {rst_in, exec_req_in, exec_write_in, exec_paged_in, pager_fill_in} = 5'b10000;
    {exec_addr_in, slot_addr_in, exec_wdata_in, wr_data_in} = '0;
    {slot_write_in, slot_exec_table_in, wr_valid_in, rd_ready_in, slot_mask_in} = '0;
    {slot_req_in, pager_fill_vpage_in, pager_fill_ppage_in} = '0;
    exec_base_in = 13'h0005;
    errors = 0;
    comparisons = 0;
    repeat (10) @(posedge sys_clk_in);
    #1;
    rst_in = 0;
    for (int i = 0; i < 4; i++) wdat[i] = 36'hA00000010 + 36'(i);
    edat = wdat;
    xfer(1, 0, 4'hF, 22'h000010, 0);
    xfer(0, 0, 4'hF, 22'h000010, 40);
    exec_op(0, 0, 22'h000011, 36'h0, 0, edat[1]);
    exec_op(1, 0, 22'h000005, 36'h123456789, 0, 36'h0);
    exec_op(0, 0, 22'h000005, 36'h0, 0, 36'h123456789);
    exec_op(0, 1, {13'h0123, 9'h011}, 36'h0, 1, 36'h0);
    {pager_fill_in, pager_fill_vpage_in, pager_fill_ppage_in} = {1'b1, 13'h0ABC, 13'h0000};
    step();
    pager_fill_in = 0;
    exec_op(0, 1, {13'h0ABC, 9'h011}, 36'h0, 0, edat[1]);
    for (int i = 0; i < 4; i++) wdat[i] = 36'hB00000020 + 36'(i);
    xfer(1, 0, 4'hF, 22'h000020, 0);
    edat = wdat;
    for (int i = 1; i < 3; i++) wdat[i] = 36'hC00000020 + 36'(i);
    xfer(1, 0, 4'h6, 22'h000020, 0);
    edat[1] = wdat[1];
    edat[2] = wdat[2];
    xfer(0, 0, 4'hF, 22'h000020, 0);
    xfer(0, 0, 4'h4, 22'h000020, 0);
    wdat[0] = 36'hD00000000;
    wdat[1] = 36'hD00000001;
    xfer(1, 1, 4'h3, {13'h1FFF, 9'h028}, 0);
    exec_op(0, 0, {13'h0005, 9'h028}, 36'h0, 0, wdat[0]);
    exec_op(0, 0, {13'h0005, 9'h029}, 36'h0, 0, wdat[1]);
    edat[0] = wdat[0];
    xfer(0, 1, 4'h1, {13'h1FFF, 9'h028}, 0);
    // two slots backed up, then an execution-unit read joins
    {slot_write_in, slot_exec_table_in, slot_mask_in, slot_addr_in} = {2'b00, 4'h1, 22'h10};
    {slot_req_in, rd_ready_in, ackd, saw_res} = {8'h81, 1'b1, 8'h00, 1'b0};
    edat[0] = 36'hA00000010;
    k = 0;
    while (k < 50 && link.io_channel_request !== 1'b1) begin
      step();
      k++;
    end
    {exec_write_in, exec_paged_in, exec_addr_in, exec_req_in} = {2'b00, 22'h12, 1'b1};
    {k, got, done_at, first_ack} = {32'd0, 32'd0, -32'd1, -32'd1};
    while (k < 800 && (ackd != 8'h81 || got < 2 || done_at < 0)) begin
      #18;
      if (link.reserve_next_core_cycle === 1'b1) saw_res = 1;
      if (rd_valid_out === 1'b1) begin
        chk(rd_data_out, edat[0], "shared read");
        got++;
      end
      for (int j = 0; j < 8; j += 7) begin
        if (slot_ack_out[j] === 1'b1 && first_ack < 0) first_ack = k;
        if (slot_ack_out[j] === 1'b1) ackd[j] = 1'b1;
      end
      if (exec_done_out === 1'b1 && done_at < 0) done_at = k;
      step();
      slot_req_in = 8'h81 & ~ackd;
      if (done_at >= 0) exec_req_in = 0;
      k++;
    end
    chk(36'({ackd == 8'h81, got == 2}), 36'h3, "both slots served");
    chk(36'(first_ack >= 0 && first_ack < done_at), 36'h1, "channel first");
    chk(36'(saw_res), 36'h1, "reserve raised");
    chk(exec_rdata_out, 36'hA00000012, "exec after channel");
    close_out();
  end
endmodule
